/* File: inc/mas_pkg.sv */
`default_nettype none
package mas_pkg;
  // ----------------------------------------
  // register map and reset values
  // ----------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'hD0;
  localparam logic [7:0] ADDR_MAIN = 8'hE0;
  localparam logic [7:0] ADDR_HELPER = 8'hF0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int BANK_SHIFT = 3;
  // status word field positions, bit 7 down
  localparam int POS_CARRY = 7;
  localparam int POS_HALF = 6;
  localparam int POS_FLAG0 = 5;
  localparam int POS_BANK_HI = 4;
  localparam int POS_BANK_LO = 3;
  localparam int POS_WRAP = 2;
  localparam int POS_FLAG1 = 1;
  localparam int POS_PARITY = 0;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    AOP_ADD = 4'h0, AOP_ADDC = 4'h1, AOP_SUBB = 4'h2, AOP_INC = 4'h3, AOP_DEC = 4'h4,
    AOP_MUL = 4'h5, AOP_DIV = 4'h6, AOP_DA = 4'h7, AOP_CMP = 4'h8
  } mas_aop_t;

  typedef enum logic [4:0] {
    CLS_NONE = 5'h00, CLS_ARITH = 5'h01, CLS_ORL = 5'h02, CLS_ANL = 5'h03, CLS_XRL = 5'h04,
    CLS_CLRA = 5'h05, CLS_CPLA = 5'h06, CLS_RL = 5'h07, CLS_RLC = 5'h08, CLS_RR = 5'h09,
    CLS_RRC = 5'h0A, CLS_SWAP = 5'h0B, CLS_CLRC = 5'h0C, CLS_SETBC = 5'h0D,
    CLS_CPLC = 5'h0E, CLS_CLRBIT = 5'h0F, CLS_SETBBIT = 5'h10, CLS_CPLBIT = 5'h11,
    CLS_MOVCB = 5'h12, CLS_MOVBC = 5'h13, CLS_ANLCB = 5'h14, CLS_ORLCB = 5'h15,
    CLS_JB = 5'h16, CLS_JNB = 5'h17, CLS_JBC = 5'h18, CLS_CJNE = 5'h19
  } mas_cls_t;

  typedef struct packed {
    mas_cls_t cls;
    mas_aop_t aop;
  } mas_dec_t;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [7:0] bitAddr;
  } mas_instr_t;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] resHigh;
    logic carry;
    logic halfCarry;
    logic signedWrap;
  } mas_arith_t;

  typedef struct packed {
    logic carry;
    logic halfCarry;
    logic flagZero;
    logic [1:0] bank;
    logic signedWrap;
    logic flagOne;
    logic parity;
  } mas_status_t;
endpackage : mas_pkg
`default_nettype wire

/* File: design/mas_arith.sv */
`timescale 1ns/100ps
`default_nettype none
module mas_arith (
  // operation
  input wire mas_pkg::mas_aop_t aop,
  input wire logic [7:0] left,
  input wire logic [7:0] right,
  // incoming flags
  input wire logic carryIn,
  input wire logic halfIn,
  input wire logic wrapIn,
  // result
  output var mas_pkg::mas_arith_t result
);
  // returns carry7, carry3, signed wrap, sum
  function automatic logic [10:0] addc(input logic [7:0] x, input logic [7:0] y,
                                       input logic c);
    logic [4:0] lo;
    logic [8:0] full;
    logic [7:0] low7;
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, c};
    full = {1'b0, x} + {1'b0, y} + {8'h00, c};
    low7 = {1'b0, x[6:0]} + {1'b0, y[6:0]} + {7'h00, c};
    return {full[8], lo[4], full[8] ^ low7[7], full[7:0]};
  endfunction : addc

  logic [10:0] sum;
  logic [15:0] prod;
  logic [8:0] adj;
  logic adjCarry;

  always_comb begin
    sum = 11'h000;
    adj = {1'b0, left};
    adjCarry = carryIn;
    prod = {8'h00, left} * {8'h00, right};
    result = '{res: left, resHigh: right, carry: carryIn, halfCarry: halfIn,
               signedWrap: wrapIn};
    case (aop)
      mas_pkg::AOP_ADD, mas_pkg::AOP_ADDC: begin
        sum = addc(left, right, (aop == mas_pkg::AOP_ADDC) ? carryIn : 1'b0);
        result.res = sum[7:0];
        result.carry = sum[10];
        result.halfCarry = sum[9];
        result.signedWrap = sum[8];
      end
      mas_pkg::AOP_SUBB: begin
        // borrow is the inverted carry of the complement add
        sum = addc(left, ~right, ~carryIn);
        result.res = sum[7:0];
        result.carry = ~sum[10];
        result.halfCarry = ~sum[9];
        result.signedWrap = sum[8];
      end
      mas_pkg::AOP_INC: result.res = left + 8'h01;
      mas_pkg::AOP_DEC: result.res = left - 8'h01;
      mas_pkg::AOP_MUL: begin
        result.res = prod[7:0];
        result.resHigh = prod[15:8];
        result.carry = 1'b0;
        result.signedWrap = |prod[15:8];
      end
      mas_pkg::AOP_DIV: begin
        result.carry = 1'b0;
        // divide by zero leaves both operands untouched
        if (right == 8'h00) begin
          result.signedWrap = 1'b1;
        end else begin
          result.res = left / right;
          result.resHigh = left % right;
          result.signedWrap = 1'b0;
        end
      end
      mas_pkg::AOP_DA: begin
        if (left[3:0] > 4'h9 || halfIn) begin
          adj = adj + 9'h006;
        end
        adjCarry = carryIn | adj[8];
        if (adj[7:4] > 4'h9 || adjCarry) begin
          adj = {1'b0, adj[7:0]} + 9'h060;
          adjCarry = adjCarry | adj[8];
        end
        result.res = adj[7:0];
        result.carry = adjCarry;
      end
      mas_pkg::AOP_CMP: result.carry = (left < right);
      default: result.res = left;
    endcase
  end
endmodule : mas_arith
`default_nettype wire

/* File: design/mas_alu_status.sv */
// Functional notes
// - decodes standard instruction set binary encodings
// - main operand register, bit addressable, resets zero
// - helper register holds multiply/divide second operand
// - add, subtract, multiply, divide, inc, dec, adjust, compare
// - AND, OR, XOR, complement, rotate on bytes
// - bit set, clear, complement, jumps, carry moves
// - status word layout fixed, resets zero
// - bank select picks one of four ranges
// - every special register read, write, modify
`timescale 1ns/100ps
`default_nettype none
module mas_alu_status (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // instruction decoder
  input wire mas_pkg::mas_instr_t instr,
  input wire logic extBitIn,
  // special register bus
  input wire logic [7:0] sregAddr,
  input wire logic sregWe,
  input wire logic sregRe,
  input wire logic [7:0] sregWdata,
  // register read answer
  output logic [7:0] sregRdata,
  output logic sregHit,
  // execution results
  output logic done,
  output logic jumpTaken,
  output logic extBitWe,
  output logic [7:0] extBitAddr,
  output logic extBitData,
  // register views
  output logic [7:0] mainOperand,
  output logic [7:0] helperValue,
  output logic [7:0] statusWord,
  output logic [7:0] bankBase
);
  // --------------------------------------------------
  // decode helpers
  // --------------------------------------------------
  // 0 none, 1 status, 2 main, 3 helper
  function automatic logic [1:0] regSel(input logic [7:0] addr);
    case (addr)
      mas_pkg::ADDR_STATUS: return 2'd1;
      mas_pkg::ADDR_MAIN: return 2'd2;
      mas_pkg::ADDR_HELPER: return 2'd3;
      default: return 2'd0;
    endcase
  endfunction : regSel

  // only bit addresses at or above 0x80 map onto special registers
  function automatic logic [1:0] bitSel(input logic [7:0] addr);
    return addr[7] ? regSel({addr[7:3], 3'b000}) : 2'd0;
  endfunction : bitSel

  function automatic mas_pkg::mas_dec_t decodeOp(input logic [7:0] op);
    mas_pkg::mas_dec_t d;
    d = '{cls: mas_pkg::CLS_NONE, aop: mas_pkg::AOP_ADD};
    if (op[3:0] >= 4'h4) begin
      case (op[7:4])
        4'h2: d = '{cls: mas_pkg::CLS_ARITH, aop: mas_pkg::AOP_ADD};
        4'h3: d = '{cls: mas_pkg::CLS_ARITH, aop: mas_pkg::AOP_ADDC};
        4'h4: d.cls = mas_pkg::CLS_ORL;
        4'h5: d.cls = mas_pkg::CLS_ANL;
        4'h6: d.cls = mas_pkg::CLS_XRL;
        4'h9: d = '{cls: mas_pkg::CLS_ARITH, aop: mas_pkg::AOP_SUBB};
        default: d.cls = mas_pkg::CLS_NONE;
      endcase
    end
    case (op)
      8'h04: d = '{cls: mas_pkg::CLS_ARITH, aop: mas_pkg::AOP_INC};
      8'h14: d = '{cls: mas_pkg::CLS_ARITH, aop: mas_pkg::AOP_DEC};
      8'hA4: d = '{cls: mas_pkg::CLS_ARITH, aop: mas_pkg::AOP_MUL};
      8'h84: d = '{cls: mas_pkg::CLS_ARITH, aop: mas_pkg::AOP_DIV};
      8'hD4: d = '{cls: mas_pkg::CLS_ARITH, aop: mas_pkg::AOP_DA};
      8'hB4, 8'hB5: d = '{cls: mas_pkg::CLS_CJNE, aop: mas_pkg::AOP_CMP};
      8'hE4: d.cls = mas_pkg::CLS_CLRA;
      8'hF4: d.cls = mas_pkg::CLS_CPLA;
      8'h23: d.cls = mas_pkg::CLS_RL;
      8'h33: d.cls = mas_pkg::CLS_RLC;
      8'h03: d.cls = mas_pkg::CLS_RR;
      8'h13: d.cls = mas_pkg::CLS_RRC;
      8'hC4: d.cls = mas_pkg::CLS_SWAP;
      8'hC3: d.cls = mas_pkg::CLS_CLRC;
      8'hD3: d.cls = mas_pkg::CLS_SETBC;
      8'hB3: d.cls = mas_pkg::CLS_CPLC;
      8'hC2: d.cls = mas_pkg::CLS_CLRBIT;
      8'hD2: d.cls = mas_pkg::CLS_SETBBIT;
      8'hB2: d.cls = mas_pkg::CLS_CPLBIT;
      8'hA2: d.cls = mas_pkg::CLS_MOVCB;
      8'h92: d.cls = mas_pkg::CLS_MOVBC;
      8'h82: d.cls = mas_pkg::CLS_ANLCB;
      8'h72: d.cls = mas_pkg::CLS_ORLCB;
      8'h20: d.cls = mas_pkg::CLS_JB;
      8'h30: d.cls = mas_pkg::CLS_JNB;
      8'h10: d.cls = mas_pkg::CLS_JBC;
      default: d = d;
    endcase
    return d;
  endfunction : decodeOp

  // --------------------------------------------------
  // state
  // --------------------------------------------------
  logic [7:0] main_reg, main_next;
  logic [7:0] helper_reg, helper_next;
  mas_pkg::mas_status_t status_reg, status_next;
  logic [7:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;
  logic done_reg, done_next;
  logic jump_reg, jump_next;
  logic extWe_reg, extWe_next;
  logic [7:0] extAddr_reg, extAddr_next;
  logic extData_reg, extData_next;
  logic [7:0] bank_reg, bank_next;

  mas_pkg::mas_dec_t dec;
  mas_pkg::mas_arith_t arith;
  logic [1:0] bitOwner;
  logic [2:0] bitPos;
  logic curBit, newBit, bitWrite;

  assign dec = decodeOp(instr.opcode);
  assign bitOwner = bitSel(instr.bitAddr);
  assign bitPos = instr.bitAddr[2:0];

  // --------------------------------------------------
  // arithmetic unit
  // --------------------------------------------------
  mas_arith u_arith (
    .aop(dec.aop),
    .left(main_reg),
    .right((dec.aop == mas_pkg::AOP_MUL || dec.aop == mas_pkg::AOP_DIV) ?
           helper_reg : instr.operand),
    .carryIn(status_reg.carry),
    .halfIn(status_reg.halfCarry),
    .wrapIn(status_reg.signedWrap),
    .result(arith)
  );

  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb begin
    main_next = main_reg;
    helper_next = helper_reg;
    status_next = status_reg;
    done_next = 1'b0;
    jump_next = 1'b0;
    extWe_next = 1'b0;
    extAddr_next = extAddr_reg;
    extData_next = extData_reg;
    newBit = 1'b0;
    bitWrite = 1'b0;
    case (bitOwner)
      2'd1: curBit = status_reg[bitPos];
      2'd2: curBit = main_reg[bitPos];
      2'd3: curBit = helper_reg[bitPos];
      default: curBit = extBitIn;
    endcase
    if (instr.valid) begin
      done_next = 1'b1;
      case (dec.cls)
        mas_pkg::CLS_ARITH: begin
          main_next = arith.res;
          status_next.carry = arith.carry;
          status_next.halfCarry = arith.halfCarry;
          status_next.signedWrap = arith.signedWrap;
          if (dec.aop == mas_pkg::AOP_MUL || dec.aop == mas_pkg::AOP_DIV) begin
            helper_next = arith.resHigh;
          end
        end
        mas_pkg::CLS_CJNE: begin
          status_next.carry = arith.carry;
          jump_next = (main_reg != instr.operand);
        end
        mas_pkg::CLS_ORL: main_next = main_reg | instr.operand;
        mas_pkg::CLS_ANL: main_next = main_reg & instr.operand;
        mas_pkg::CLS_XRL: main_next = main_reg ^ instr.operand;
        mas_pkg::CLS_CLRA: main_next = 8'h00;
        mas_pkg::CLS_CPLA: main_next = ~main_reg;
        mas_pkg::CLS_RL: main_next = {main_reg[6:0], main_reg[7]};
        mas_pkg::CLS_RR: main_next = {main_reg[0], main_reg[7:1]};
        mas_pkg::CLS_RLC: begin
          main_next = {main_reg[6:0], status_reg.carry};
          status_next.carry = main_reg[7];
        end
        mas_pkg::CLS_RRC: begin
          main_next = {status_reg.carry, main_reg[7:1]};
          status_next.carry = main_reg[0];
        end
        mas_pkg::CLS_SWAP: main_next = {main_reg[3:0], main_reg[7:4]};
        mas_pkg::CLS_CLRC: status_next.carry = 1'b0;
        mas_pkg::CLS_SETBC: status_next.carry = 1'b1;
        mas_pkg::CLS_CPLC: status_next.carry = ~status_reg.carry;
        mas_pkg::CLS_MOVCB: status_next.carry = curBit;
        mas_pkg::CLS_ANLCB: status_next.carry = status_reg.carry & curBit;
        mas_pkg::CLS_ORLCB: status_next.carry = status_reg.carry | curBit;
        mas_pkg::CLS_CLRBIT, mas_pkg::CLS_SETBBIT, mas_pkg::CLS_CPLBIT,
        mas_pkg::CLS_MOVBC: begin
          bitWrite = 1'b1;
          case (dec.cls)
            mas_pkg::CLS_SETBBIT: newBit = 1'b1;
            mas_pkg::CLS_CPLBIT: newBit = ~curBit;
            mas_pkg::CLS_MOVBC: newBit = status_reg.carry;
            default: newBit = 1'b0;
          endcase
        end
        mas_pkg::CLS_JB: jump_next = curBit;
        mas_pkg::CLS_JNB: jump_next = ~curBit;
        mas_pkg::CLS_JBC: begin
          jump_next = curBit;
          bitWrite = curBit;
          newBit = 1'b0;
        end
        default: done_next = 1'b1;
      endcase
    end
    if (bitWrite) begin
      case (bitOwner)
        2'd1: status_next[bitPos] = newBit;
        2'd2: main_next[bitPos] = newBit;
        2'd3: helper_next[bitPos] = newBit;
        default: begin
          extWe_next = 1'b1;
          extAddr_next = instr.bitAddr;
          extData_next = newBit;
        end
      endcase
    end
    // a bus write lands after the instruction, so it wins on the same register
    if (sregWe) begin
      case (regSel(sregAddr))
        2'd1: status_next = sregWdata;
        2'd2: main_next = sregWdata;
        2'd3: helper_next = sregWdata;
        default: main_next = main_next;
      endcase
    end
    // parity is never software-owned; writes to it are overridden here
    status_next.parity = ^main_next;
    bank_next = 8'(status_next.bank) << mas_pkg::BANK_SHIFT;
    hit_next = sregRe && (regSel(sregAddr) != 2'd0);
    case (sregRe ? regSel(sregAddr) : 2'd0)
      2'd1: rdata_next = status_reg;
      2'd2: rdata_next = main_reg;
      2'd3: rdata_next = helper_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // --------------------------------------------------
  // registers
  // --------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      main_reg <= mas_pkg::RESET_BYTE;
      helper_reg <= mas_pkg::RESET_BYTE;
      status_reg <= mas_pkg::RESET_BYTE;
      rdata_reg <= 8'h00;
      hit_reg <= 1'b0;
      done_reg <= 1'b0;
      jump_reg <= 1'b0;
      extWe_reg <= 1'b0;
      extAddr_reg <= 8'h00;
      extData_reg <= 1'b0;
      bank_reg <= 8'h00;
    end else begin
      main_reg <= main_next;
      helper_reg <= helper_next;
      status_reg <= status_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
      done_reg <= done_next;
      jump_reg <= jump_next;
      extWe_reg <= extWe_next;
      extAddr_reg <= extAddr_next;
      extData_reg <= extData_next;
      bank_reg <= bank_next;
    end
  end

  assign sregRdata = rdata_reg;
  assign sregHit = hit_reg;
  assign done = done_reg;
  assign jumpTaken = jump_reg;
  assign extBitWe = extWe_reg;
  assign extBitAddr = extAddr_reg;
  assign extBitData = extData_reg;
  assign mainOperand = main_reg;
  assign helperValue = helper_reg;
  assign statusWord = status_reg;
  assign bankBase = bank_reg;
endmodule : mas_alu_status
`default_nettype wire

/* File: testbench/mas_alu_status_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module mas_alu_status_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // requests
  input wire mas_pkg::mas_instr_t instr,
  input wire logic [7:0] sregAddr,
  input wire logic sregWe,
  input wire logic sregRe,
  input wire logic [7:0] sregWdata,
  // answers
  input wire logic [7:0] sregRdata,
  input wire logic sregHit,
  input wire logic done,
  input wire logic jumpTaken,
  input wire logic [7:0] mainOperand,
  input wire logic [7:0] helperValue,
  input wire logic [7:0] statusWord,
  input wire logic [7:0] bankBase
);
  // ------
  // properties
  // ------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic mapped;
  assign mapped = (sregAddr == mas_pkg::ADDR_STATUS) || (sregAddr == mas_pkg::ADDR_MAIN)
    || (sregAddr == mas_pkg::ADDR_HELPER);
  chk_done_follows: assert property (instr.valid |=> done)
    else $error("done missing after instruction");
  chk_done_alone: assert property (!instr.valid |=> !done && !jumpTaken)
    else $error("done without instruction");
  chk_parity_odd: assert property (statusWord[0] == ^mainOperand)
    else $error("parity flag wrong");
  chk_bank_base: assert property (bankBase == {3'b000, statusWord[4:3], 3'b000})
    else $error("bank base wrong");
  chk_read_main: assert property (sregRe && sregAddr == mas_pkg::ADDR_MAIN
    |=> sregHit && sregRdata == $past(mainOperand))
    else $error("main read wrong");
  chk_read_unmapped: assert property (sregRe && !mapped |=> !sregHit && sregRdata == 8'h00)
    else $error("unmapped read answered");
  chk_no_read: assert property (!sregRe |=> !sregHit && sregRdata == 8'h00)
    else $error("read data without read");
  chk_write_helper: assert property (sregWe && sregAddr == mas_pkg::ADDR_HELPER
    |=> helperValue == $past(sregWdata))
    else $error("helper write lost");
  chk_write_status: assert property (sregWe && sregAddr == mas_pkg::ADDR_STATUS
    |=> (statusWord & 8'hFE) == ($past(sregWdata) & 8'hFE))
    else $error("status write lost");
  chk_jump_done: assert property (jumpTaken |-> done)
    else $error("jump outside done");
endmodule : mas_alu_status_chk
bind mas_alu_status mas_alu_status_chk u_chk (.core_clk(core_clk), .rstn(rstn), .instr(instr),
  .sregAddr(sregAddr), .sregWe(sregWe), .sregRe(sregRe), .sregWdata(sregWdata),
  .sregRdata(sregRdata), .sregHit(sregHit), .done(done), .jumpTaken(jumpTaken),
  .mainOperand(mainOperand), .helperValue(helperValue), .statusWord(statusWord),
  .bankBase(bankBase));
`default_nettype wire

/* File: testbench/mas_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mas_host_model (
  // clock
  input wire logic core_clk,
  // toward the block
  output var mas_pkg::mas_instr_t instr,
  output var logic extBitIn,
  output var logic [7:0] sregAddr,
  output var logic sregWe,
  output var logic sregRe,
  output var logic [7:0] sregWdata,
  // from the block
  input wire logic [7:0] sregRdata,
  input wire logic sregHit,
  input wire logic done,
  input wire logic jumpTaken,
  input wire logic extBitWe,
  input wire logic [7:0] extBitAddr,
  input wire logic extBitData
);
  logic bitMem [256];
  logic [7:0] rdData;
  logic rdHit, gotDone, gotJump, gotBitWe;
  initial begin
    instr = '0;
    sregAddr = 8'h00;
    sregWe = 1'b0;
    sregRe = 1'b0;
    sregWdata = 8'h00;
    for (int i = 0; i < 256; i++) bitMem[i] = 1'(i);
  end
  // outside bit space answers at once, as the decoder expects
  assign extBitIn = bitMem[instr.bitAddr];
  always @(posedge core_clk) if (extBitWe) bitMem[extBitAddr] <= extBitData;
  // ------
  // requests; released fields show inverted values so stale data is not reused
  // ------
  task automatic exec(input logic [7:0] op, input logic [7:0] opd, input logic [7:0] ba);
    @(posedge core_clk);
    instr <= {1'b1, op, opd, ba};
    @(posedge core_clk);
    instr <= {1'b0, ~op, ~opd, ~ba};
    #1;
    gotDone = done;
    gotJump = jumpTaken;
    gotBitWe = extBitWe;
  endtask : exec
  task automatic regAcc(input logic wr, input logic [7:0] adr, input logic [7:0] dat);
    @(posedge core_clk);
    sregWe <= wr;
    sregRe <= !wr;
    sregAddr <= adr;
    sregWdata <= dat;
    @(posedge core_clk);
    sregWe <= 1'b0;
    sregRe <= 1'b0;
    sregAddr <= ~adr;
    sregWdata <= ~dat;
    #1;
    rdData = sregRdata;
    rdHit = sregHit;
  endtask : regAcc
endmodule : mas_host_model
`default_nettype wire

/* File: testbench/tb_mcu_alu_status.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("FAIL %s exp %h got %h", nm, exp, got); end end
module tb_mcu_alu_status;
  localparam int PCAR = mas_pkg::POS_CARRY;
  localparam int PHLF = mas_pkg::POS_HALF;
  localparam int PWRP = mas_pkg::POS_WRAP;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  mas_pkg::mas_instr_t instr;
  logic extBitIn, sregWe, sregRe, sregHit, done, jumpTaken, extBitWe, extBitData;
  logic [7:0] sregAddr, sregWdata, sregRdata, extBitAddr;
  logic [7:0] mainOperand, helperValue, statusWord, bankBase;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [2:0] arithFlags;
  assign arithFlags = {statusWord[PCAR], statusWord[PHLF], statusWord[PWRP]};
  always #5 core_clk = ~core_clk;
  mas_alu_status u_dut (.core_clk(core_clk), .rstn(rstn), .instr(instr), .extBitIn(extBitIn),
    .sregAddr(sregAddr), .sregWe(sregWe), .sregRe(sregRe), .sregWdata(sregWdata),
    .sregRdata(sregRdata), .sregHit(sregHit), .done(done), .jumpTaken(jumpTaken),
    .extBitWe(extBitWe), .extBitAddr(extBitAddr), .extBitData(extBitData),
    .mainOperand(mainOperand), .helperValue(helperValue), .statusWord(statusWord),
    .bankBase(bankBase));
  mas_host_model u_host (.core_clk(core_clk), .instr(instr), .extBitIn(extBitIn),
    .sregAddr(sregAddr), .sregWe(sregWe), .sregRe(sregRe), .sregWdata(sregWdata),
    .sregRdata(sregRdata), .sregHit(sregHit), .done(done), .jumpTaken(jumpTaken),
    .extBitWe(extBitWe), .extBitAddr(extBitAddr), .extBitData(extBitData));
  // ------
  // shared steps
  // ------
  task automatic ex(input logic [7:0] op, input logic [7:0] opd, input logic [7:0] ba);
    u_host.exec(op, opd, ba);
    `CHK("done", 1'b1, u_host.gotDone)
  endtask : ex
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    u_host.regAcc(1'b1, adr, dat);
  endtask : wr
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  // ------
  // scenarios
  // ------
  task automatic t_regs;
    logic [7:0] adr [4];
    adr = '{mas_pkg::ADDR_STATUS, mas_pkg::ADDR_MAIN, mas_pkg::ADDR_HELPER, 8'h81};
    for (int i = 0; i < 4; i++) begin
      u_host.regAcc(1'b0, adr[i], 8'h00);
      `CHK("rdata", 8'h00, u_host.rdData)
      `CHK("hit", 1'(i < 3), u_host.rdHit)
    end
    // parity bit written as one must not stick while main is zero
    for (int b = 0; b < 4; b++) begin
      wr(mas_pkg::ADDR_STATUS, 8'(b << 3) | 8'h01);
      `CHK("bank", 8'(b * 8), bankBase)
      `CHK("parity", 1'b0, statusWord[0])
    end
    wr(mas_pkg::ADDR_MAIN, 8'h07);
    `CHK("parity", 1'b1, statusWord[0])
    wr(mas_pkg::ADDR_HELPER, 8'h3C);
    wr(8'hE1, 8'hFF);
    u_host.regAcc(1'b0, mas_pkg::ADDR_HELPER, 8'h00);
    `CHK("helper", 8'h3C, u_host.rdData)
    `CHK("main", 8'h07, mainOperand)
    $display("test regs done");
  endtask : t_regs
  task automatic t_arith;
    wr(mas_pkg::ADDR_MAIN, 8'hFF);
    ex(8'h24, 8'h01, 8'h00);
    `CHK("add", 11'h006, {mainOperand, arithFlags})
    wr(mas_pkg::ADDR_MAIN, 8'h7F);
    ex(8'h24, 8'h01, 8'h00);
    `CHK("add", 11'h403, {mainOperand, arithFlags})
    ex(8'h94, 8'h01, 8'h00);
    `CHK("sub", 11'h3FB, {mainOperand, arithFlags})
    wr(mas_pkg::ADDR_MAIN, 8'h10);
    wr(mas_pkg::ADDR_HELPER, 8'h20);
    ex(8'hA4, 8'h00, 8'h00);
    `CHK("mul", 18'h0_0009, {mainOperand, helperValue, statusWord[PCAR], statusWord[PWRP]})
    wr(mas_pkg::ADDR_MAIN, 8'hFA);
    wr(mas_pkg::ADDR_HELPER, 8'h10);
    ex(8'h84, 8'h00, 8'h00);
    `CHK("div", 18'h03C28, {mainOperand, helperValue, statusWord[PCAR], statusWord[PWRP]})
    wr(mas_pkg::ADDR_MAIN, 8'h33);
    wr(mas_pkg::ADDR_HELPER, 8'h00);
    ex(8'h84, 8'h00, 8'h00);
    `CHK("div0", 17'h06601, {mainOperand, helperValue, statusWord[PWRP]})
    ex(8'hB4, 8'h40, 8'h00);
    `CHK("cmp", 2'b11, {u_host.gotJump, statusWord[PCAR]})
    wr(mas_pkg::ADDR_MAIN, 8'h3C);
    ex(8'hD4, 8'h00, 8'h00);
    `CHK("adjust", 9'h145, {mainOperand, statusWord[PCAR]})
    // carry left set by the adjust must feed the add
    ex(8'h34, 8'h01, 8'h00);
    `CHK("addc", 11'h520, {mainOperand, arithFlags})
    $display("test arith done");
  endtask : t_arith
  task automatic t_logic;
    logic [7:0] op [11];
    logic [7:0] res [11];
    op = '{8'h54, 8'h44, 8'h64, 8'hF4, 8'h23, 8'h03, 8'h04, 8'h14, 8'hC4, 8'hE4, 8'hA5};
    res = '{8'h0A, 8'h5F, 8'hA5, 8'hA5, 8'hB4, 8'h2D, 8'h5B, 8'h59, 8'hA5, 8'h00, 8'h5A};
    for (int i = 0; i < 11; i++) begin
      wr(mas_pkg::ADDR_MAIN, 8'h5A);
      ex(op[i], (i == 2) ? 8'hFF : 8'h0F, 8'h00);
      `CHK("logic", res[i], mainOperand)
    end
    $display("test logic done");
  endtask : t_logic
  task automatic t_bits;
    ex(8'hD3, 8'h00, 8'h00);
    `CHK("setc", 1'b1, statusWord[PCAR])
    ex(8'hB3, 8'h00, 8'h00);
    `CHK("cplc", 1'b0, statusWord[PCAR])
    wr(mas_pkg::ADDR_MAIN, 8'h80);
    ex(8'h10, 8'h00, 8'hE7);
    `CHK("jbc", 9'h100, {u_host.gotJump, mainOperand})
    ex(8'h20, 8'h00, 8'hE7);
    `CHK("jb", 1'b0, u_host.gotJump)
    ex(8'h30, 8'h00, 8'hE7);
    `CHK("jnb", 1'b1, u_host.gotJump)
    ex(8'hD2, 8'h00, 8'h20);
    `CHK("extset", 10'h241, {u_host.gotBitWe, extBitAddr, extBitData})
    ex(8'hA2, 8'h00, 8'h20);
    `CHK("movcb", 1'b1, statusWord[PCAR])
    ex(8'hC3, 8'h00, 8'h00);
    `CHK("clrc", 1'b0, statusWord[PCAR])
    ex(8'hD2, 8'h00, 8'hD5);
    `CHK("flag0", 1'b1, statusWord[mas_pkg::POS_FLAG0])
    wr(mas_pkg::ADDR_MAIN, 8'h81);
    ex(8'h33, 8'h00, 8'h00);
    `CHK("rlc", 9'h005, {mainOperand, statusWord[PCAR]})
    ex(8'h13, 8'h00, 8'h00);
    `CHK("rrc", 9'h102, {mainOperand, statusWord[PCAR]})
    ex(8'hD3, 8'h00, 8'h00);
    ex(8'h92, 8'h00, 8'hF3);
    `CHK("movbc", 8'h08, helperValue)
    ex(8'hB2, 8'h00, 8'hF3);
    `CHK("cplbit", 8'h00, helperValue)
    ex(8'hC2, 8'h00, 8'hE0);
    `CHK("clrbit", 8'h80, mainOperand)
    ex(8'h82, 8'h00, 8'hE0);
    `CHK("anlcb", 1'b0, statusWord[PCAR])
    ex(8'h72, 8'h00, 8'hE7);
    `CHK("orlcb", 1'b1, statusWord[PCAR])
    $display("test bits done");
  endtask : t_bits
  task automatic t_reset;
    // mid-run reset must clear a status word that is far from zero
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    `CHK("reset", 32'h0000_0000, {mainOperand, helperValue, statusWord, bankBase})
    $display("test reset done");
  endtask : t_reset
  // ------
  // sequence and hang guard
  // ------
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    t_regs();
    t_arith();
    t_logic();
    t_bits();
    t_reset();
    final_report();
  end
endmodule : tb_mcu_alu_status
`default_nettype wire
